//--- fsm_monitor.sv
// Filter service monitor: menu, service life, replacement sequence, AXI4-Lite registers
//
// Summary of operation
// - Service life in months, default 6, accepted range 1 to 24.
// - Elapsed time 0 to 24 months, half-month steps below 10 months.
// - Confirm steps readout: channel, monitoring, life, replacement, year, month, day, time.
// - Write mode offers monitoring on, service life, replacement, monitoring off.
// - Advance steps edited service life from 1 up to 24.
// - One set of settings, shown under the first channel; that channel must be confirmed before an action.
// - Replacement start: flashing code, isolate sensor, fault, fault lamp, elapsed zero.
// - Reset key during replacement completes it, clearing fault, isolation and code.
// - Reset key held over 15 s with monitoring on starts a replacement.
// - Reset key held over 10 s gives the lamp test first.
// - Reset key disabled by configuration: long hold starts no replacement.
// - No button action within 5 s abandons the menu back to idle.
//
// Local design decisions: the register addresses and the AXI4-Lite slave port.
module fsm_monitor #(
  parameter int unsigned LAMP_CYC = fsm_pkg::LAMP_HOLD_CYC,
  parameter int unsigned SWAP_CYC = fsm_pkg::SWAP_HOLD_CYC,
  parameter int unsigned MENU_CYC = fsm_pkg::MENU_TIMEOUT_CYC,
  parameter int unsigned FLASH_CYC = fsm_pkg::FLASH_HALF_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Operator pins, active low
  input wire logic btn_adv_n,
  input wire logic btn_cfm_n,
  input wire logic key_reset_n,
  // Calendar from the device clock domain
  input wire logic half_month_tick,
  input wire fsm_pkg::fsm_date_t today,
  // Operator and system outputs
  output fsm_pkg::fsm_disp_t disp,
  output logic sensor_isolate,
  output logic fault_out,
  output logic fault_led,
  output logic lamp_test,
  output logic irq,
  // AXI4-Lite write channels
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read channels
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp
);
  import fsm_pkg::*;

  logic [2:0] pin_s;
  logic [2:0] press;
  logic [2:0] prev_q;
  logic [2:0] rise;
  logic adv_r, cfm_r, key_r, key_held;
  fsm_menu_t menu_q;
  logic mode_wr_q;
  fsm_item_t item_q;
  fsm_rd_t rd_q;
  logic [4:0] edit_q;
  logic [2:0] ack_q;
  logic [TMO_W-1:0] tmo_q;
  logic tmo_hit;
  logic [FLASH_W-1:0] flash_cnt_q;
  logic flash_ph_q, flash_tick;
  logic [1:0] ctrl_q;
  logic [4:0] life_q;
  logic [HOLD_W-1:0] hold_q;
  logic swap_q, hold_start, menu_swap, swap_start, swap_done;
  logic chan_ok, mon_on, mon_off, life_store, store_evt;
  logic [5:0] elapsed_q;
  fsm_date_t last_q;
  logic [IRQ_W-1:0] stat_q, mask_q, irq_set;
  logic aw_got_q, w_got_q, do_write;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic wlane0_q;
  logic [31:0] rd_word;
  logic rd_hit;
  logic [7:0] opt_val;

  // Pin synchronisers, pins idle high
  for (genvar i = 0; i < 3; i++) begin : g_sync
    fsm_sync #(.RST_VAL(1'b1)) u_sync (
      .clk(clk),
      .rst(rst),
      .d(i == 0 ? btn_adv_n : (i == 1 ? btn_cfm_n : key_reset_n)),
      .q(pin_s[i])
    );
  end

  // Press edges from the synchronised levels
  assign press = ~pin_s;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_q <= 3'h0;
    end else begin
      prev_q <= press;
    end
  end
  assign rise = press & ~prev_q;
  assign adv_r = rise[0];
  assign cfm_r = rise[1];
  assign key_r = rise[2];
  assign key_held = press[2];

  // Flash timebase shared by ack and replacement code
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flash_cnt_q <= '0;
      flash_ph_q <= 1'b0;
    end else if (flash_tick) begin
      flash_cnt_q <= '0;
      flash_ph_q <= ~flash_ph_q;
    end else begin
      flash_cnt_q <= flash_cnt_q + 1'b1;
    end
  end
  assign flash_tick = (flash_cnt_q >= FLASH_W'(FLASH_CYC - 1));

  // Menu inactivity counter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tmo_q <= '0;
    end else if (menu_q == S_IDLE || menu_q == S_ACK || adv_r || cfm_r) begin
      tmo_q <= '0;
    end else if (!tmo_hit) begin
      tmo_q <= tmo_q + 1'b1;
    end
  end
  assign tmo_hit = (tmo_q >= TMO_W'(MENU_CYC - 1));

  // Menu actions taken on confirm
  assign chan_ok = (menu_q == S_CHAN) && cfm_r && !tmo_hit;
  assign mon_on = chan_ok && item_q == ITEM_ON;
  assign mon_off = chan_ok && item_q == ITEM_OFF;
  assign menu_swap = chan_ok && item_q == ITEM_SWAP;
  assign life_store = (menu_q == S_EDIT) && cfm_r && !tmo_hit;
  assign store_evt = mon_on || mon_off || life_store;

  // Menu state machine
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      menu_q <= S_IDLE;
      mode_wr_q <= 1'b0;
      item_q <= ITEM_ON;
      rd_q <= RD_CHAN;
      edit_q <= LIFE_RST;
      ack_q <= 3'h0;
    end else if (menu_q != S_IDLE && menu_q != S_ACK && tmo_hit) begin
      menu_q <= S_IDLE;
    end else begin
      case (menu_q)
        S_IDLE: begin
          if (cfm_r) begin
            menu_q <= S_MODE;
            mode_wr_q <= 1'b0;
          end
        end
        S_MODE: begin
          if (adv_r) begin
            mode_wr_q <= ~mode_wr_q;
          end else if (cfm_r) begin
            menu_q <= mode_wr_q ? S_ITEM : S_READ;
            item_q <= ITEM_ON;
            rd_q <= RD_CHAN;
          end
        end
        S_READ: begin
          if (cfm_r) begin
            if (rd_q == RD_OPTIME) begin
              menu_q <= S_IDLE;
            end else begin
              rd_q <= fsm_rd_t'(rd_q + 3'h1);
            end
          end
        end
        S_ITEM: begin
          if (adv_r) begin
            item_q <= fsm_item_t'(item_q + 2'h1);
          end else if (cfm_r) begin
            menu_q <= S_CHAN;
          end
        end
        S_CHAN: begin
          if (cfm_r) begin
            edit_q <= life_q;
            ack_q <= 3'h0;
            case (item_q)
              ITEM_LIFE: menu_q <= S_EDIT;
              ITEM_SWAP: menu_q <= S_IDLE;
              default: menu_q <= S_ACK;
            endcase
          end
        end
        S_EDIT: begin
          if (adv_r) begin
            edit_q <= (edit_q >= LIFE_MAX) ? LIFE_MIN : edit_q + 5'h01;
          end else if (cfm_r) begin
            menu_q <= S_ACK;
            ack_q <= 3'h0;
          end
        end
        S_ACK: begin
          if (ack_q >= ACK_TOGGLES) begin
            menu_q <= S_IDLE;
          end else if (flash_tick) begin
            ack_q <= ack_q + 3'h1;
          end
        end
        default: menu_q <= S_IDLE;
      endcase
    end
  end

  // Settings, written by the menu or by the bus; the menu wins a tie
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= CTRL_RST;
      life_q <= LIFE_RST;
    end else begin
      if (do_write && wlane0_q && awaddr_q == ADDR_CTRL) begin
        ctrl_q <= wdata_q[1:0];
      end
      if (do_write && wlane0_q && awaddr_q == ADDR_LIFE &&
          wdata_q[4:0] >= LIFE_MIN && wdata_q[4:0] <= LIFE_MAX && wdata_q[7:5] == 3'h0) begin
        life_q <= wdata_q[4:0];
      end
      if (mon_on) begin
        ctrl_q[CTRL_MON_BIT] <= 1'b1;
      end
      if (mon_off) begin
        ctrl_q[CTRL_MON_BIT] <= 1'b0;
      end
      if (life_store) begin
        life_q <= edit_q;
      end
    end
  end

  // Reset key hold timer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_q <= '0;
      lamp_test <= 1'b0;
    end else begin
      if (!key_held) begin
        hold_q <= '0;
      end else if (hold_q < HOLD_W'(SWAP_CYC)) begin
        hold_q <= hold_q + 1'b1;
      end
      lamp_test <= key_held && hold_q >= HOLD_W'(LAMP_CYC);
    end
  end
  assign hold_start = key_held && hold_q == HOLD_W'(SWAP_CYC - 1) &&
                      ctrl_q[CTRL_MON_BIT] && !ctrl_q[CTRL_KEYDIS_BIT];
  assign swap_start = (menu_swap || hold_start) && !swap_q;
  assign swap_done = swap_q && key_r && !swap_start;

  // Replacement sequence outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      swap_q <= 1'b0;
      sensor_isolate <= 1'b0;
      fault_out <= 1'b0;
      fault_led <= 1'b0;
      last_q <= '0;
    end else if (swap_start) begin
      swap_q <= 1'b1;
      sensor_isolate <= 1'b1;
      fault_out <= 1'b1;
      fault_led <= 1'b1;
    end else if (swap_done) begin
      swap_q <= 1'b0;
      sensor_isolate <= 1'b0;
      fault_out <= 1'b0;
      fault_led <= 1'b0;
      last_q <= today;
    end
  end

  // Elapsed time in half months, frozen during a replacement
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      elapsed_q <= 6'h00;
    end else if (swap_start) begin
      elapsed_q <= 6'h00;
    end else if (!swap_q && half_month_tick && elapsed_q < ELAPSED_MAX) begin
      elapsed_q <= elapsed_q + 6'h01;
    end
  end
  // Whole months from 10 months up
  assign opt_val = {2'h0, (elapsed_q < HALF_STEP_LIMIT) ? elapsed_q
                                                       : (elapsed_q & 6'h3e)};

  // Display register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      disp <= '{code: DC_IDLE, value: 8'h00, lit: 1'b1};
    end else begin
      disp.lit <= 1'b1;
      disp.value <= 8'h00;
      case (menu_q)
        S_IDLE: begin
          disp.code <= swap_q ? DC_SWAP : DC_IDLE;
          disp.lit <= flash_ph_q;
        end
        S_MODE: disp.code <= mode_wr_q ? DC_WRITE : DC_QUERY;
        S_READ: begin
          case (rd_q)
            RD_CHAN: begin
              disp.code <= DC_CHAN;
              disp.value <= CHAN_FIRST;
            end
            RD_MON: disp.code <= ctrl_q[CTRL_MON_BIT] ? DC_ON : DC_OFF;
            RD_LIFE: begin
              disp.code <= DC_LIFE;
              disp.value <= {3'h0, life_q};
            end
            RD_REPL: disp.code <= DC_REPL;
            RD_YEAR: begin
              disp.code <= DC_YEAR;
              disp.value <= {1'b0, last_q.year};
            end
            RD_MONTH: begin
              disp.code <= DC_MONTH;
              disp.value <= {4'h0, last_q.month};
            end
            RD_DAY: begin
              disp.code <= DC_DAY;
              disp.value <= {3'h0, last_q.day};
            end
            default: begin
              disp.code <= DC_OPTIME;
              disp.value <= opt_val;
            end
          endcase
        end
        S_ITEM: begin
          case (item_q)
            ITEM_ON: disp.code <= DC_ON;
            ITEM_LIFE: disp.code <= DC_LIFE;
            ITEM_SWAP: disp.code <= DC_REPL;
            default: disp.code <= DC_OFF;
          endcase
        end
        S_CHAN: begin
          disp.code <= DC_CHAN;
          disp.value <= CHAN_FIRST;
        end
        S_EDIT: begin
          disp.code <= DC_LIFE;
          disp.value <= {3'h0, edit_q};
        end
        S_ACK: begin
          disp.value <= disp.value;
          disp.lit <= ~ack_q[0]; // Starts lit, one toggle per count
        end
        default: disp.code <= DC_IDLE;
      endcase
    end
  end

  // Sticky interrupt status, set wins over write-one-to-clear
  assign irq_set = {(menu_q != S_IDLE && menu_q != S_ACK && tmo_hit), store_evt,
                    swap_done, swap_start};
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stat_q <= '0;
      mask_q <= IRQ_MASK_RST;
      irq <= 1'b0;
    end else begin
      stat_q <= (stat_q & ~((do_write && wlane0_q && awaddr_q == ADDR_IRQ_STAT) ?
                 wdata_q[IRQ_W-1:0] : 4'h0)) | irq_set;
      if (do_write && wlane0_q && awaddr_q == ADDR_IRQ_MASK) begin
        mask_q <= wdata_q[IRQ_W-1:0];
      end
      irq <= |(stat_q & mask_q);
    end
  end

  // Register read decode
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    case (araddr)
      ADDR_CTRL: rd_word[1:0] = ctrl_q;
      ADDR_LIFE: rd_word[4:0] = life_q;
      ADDR_STATUS: begin
        rd_word[5:0] = elapsed_q;
        rd_word[ST_SWAP_BIT] = swap_q;
        rd_word[ST_LAMP_BIT] = lamp_test;
        rd_word[ST_MENU_LSB +: 7] = menu_q;
      end
      ADDR_IRQ_STAT: rd_word[IRQ_W-1:0] = stat_q;
      ADDR_IRQ_MASK: rd_word[IRQ_W-1:0] = mask_q;
      ADDR_LAST_DATE: begin
        rd_word[6:0] = last_q.year;
        rd_word[DATE_MONTH_LSB +: 4] = last_q.month;
        rd_word[DATE_DAY_LSB +: 5] = last_q.day;
      end
      default: rd_hit = 1'b0;
    endcase
  end
  assign do_write = aw_got_q && w_got_q && !bvalid;

  // AXI4-Lite write path: address and data in either order, then response
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awready <= 1'b0;
      wready <= 1'b0;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wlane0_q <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      awready <= !(aw_got_q || bvalid || (awvalid && awready));
      wready <= !(w_got_q || bvalid || (wvalid && wready));
      if (awvalid && awready) begin
        aw_got_q <= 1'b1;
        awaddr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_got_q <= 1'b1;
        wdata_q <= wdata;
        wlane0_q <= wstrb[0];
      end
      if (do_write) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        bvalid <= 1'b1;
        bresp <= (awaddr_q == ADDR_CTRL || awaddr_q == ADDR_LIFE ||
                  awaddr_q == ADDR_IRQ_STAT || awaddr_q == ADDR_IRQ_MASK ||
                  awaddr_q == ADDR_STATUS || awaddr_q == ADDR_LAST_DATE) ?
                 RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read path
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else begin
      arready <= !(rvalid || (arvalid && arready));
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata <= rd_word;
        rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end
endmodule : fsm_monitor

//--- fsm_monitor_sva.sv
// Port checker of the filter service monitor
module fsm_monitor_sva
  import fsm_pkg::*;
#(
  parameter int unsigned LAMP_CYC = 40,
  parameter int unsigned SWAP_CYC = 60,
  parameter int unsigned MENU_CYC = 200
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Operator pins
  input wire logic btn_adv_n,
  input wire logic btn_cfm_n,
  input wire logic key_reset_n,
  // Watched outputs, with rready and bready
  input wire fsm_disp_t disp,
  input wire logic sensor_isolate,
  input wire logic fault_out,
  input wire logic fault_led,
  input wire logic lamp_test,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp
);
  logic [15:0] hold_q;
  logic [15:0] quiet_q;
  // Cycles the reset key has been down
  always_ff @(posedge clk or posedge rst) begin
    if (rst) hold_q <= 16'h0;
    else if (key_reset_n) hold_q <= 16'h0;
    else if (hold_q != 16'hffff) hold_q <= hold_q + 16'h1;
  end
  // Cycles since both menu buttons were last released
  always_ff @(posedge clk or posedge rst) begin
    if (rst) quiet_q <= 16'h0;
    else if (!btn_adv_n || !btn_cfm_n) quiet_q <= 16'h0;
    else if (quiet_q != 16'hffff) quiet_q <= quiet_q + 16'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  iso_fault_tie_a: assert property (sensor_isolate == fault_out && fault_out == fault_led)
    else $error("outputs disagree");
  lamp_delay_a: assert property ($rose(lamp_test) |-> hold_q >= LAMP_CYC && hold_q <= LAMP_CYC + 8)
    else $error("lamp timing");
  swap_delay_a: assert property ($rose(sensor_isolate) && !key_reset_n |->
    hold_q >= SWAP_CYC && hold_q <= SWAP_CYC + 8) else $error("start timing");
  lamp_first_a: assert property ($rose(sensor_isolate) && !key_reset_n |-> lamp_test)
    else $error("no lamp first");
  swap_done_a: assert property (sensor_isolate && $fell(key_reset_n) |-> ##[1:6] !sensor_isolate)
    else $error("not completed");
  swap_code_a: assert property ($rose(sensor_isolate) |-> ##[0:2] disp.code == DC_SWAP)
    else $error("no swap code");
  swap_clear_a: assert property ($fell(sensor_isolate) |-> ##[0:2] disp.code != DC_SWAP)
    else $error("swap code stays");
  life_range_a: assert property (disp.code == DC_LIFE |-> disp.value <= 8'h18)
    else $error("life range");
  optime_fmt_a: assert property (disp.code == DC_OPTIME |->
    disp.value <= 8'h30 && !(disp.value >= 8'h14 && disp.value[0]))
    else $error("optime format");
  chan_first_a: assert property (disp.code == DC_CHAN |-> disp.value == CHAN_FIRST)
    else $error("wrong channel shown");
  menu_tmo_a: assert property (quiet_q > MENU_CYC + 4 |-> disp.code inside {DC_IDLE, DC_SWAP})
    else $error("menu kept");
  rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("rdata dropped");
  bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("bresp dropped");
  cover property ($rose(sensor_isolate));
  cover property (disp.code == DC_OPTIME && disp.value >= 8'h14);
  cover property (quiet_q == MENU_CYC + 5);
endmodule : fsm_monitor_sva

//--- fsm_monitor_tb.sv
// Self-checking bench of the filter service monitor
module fsm_monitor_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import fsm_pkg::*;
  logic clk, rst, half_month_tick, awvalid, wvalid, bready, arvalid, rready, lit_q;
  logic btn_adv_n, btn_cfm_n, key_reset_n, sensor_isolate, fault_out, fault_led, lamp_test;
  logic irq, awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  fsm_date_t today;
  fsm_disp_t disp;
  int n_fail, samples_checked, flips, f0;
  int unsigned life, k;
  int unsigned corner[4] = '{0, 25, 24, 1};
  fsm_code_t rd_seq[9] = '{DC_CHAN, DC_ON, DC_LIFE, DC_REPL, DC_YEAR, DC_MONTH, DC_DAY,
    DC_OPTIME, DC_IDLE};
  fsm_code_t wr_seq[4] = '{DC_LIFE, DC_REPL, DC_OFF, DC_ON};

  fsm_monitor #(.LAMP_CYC(40), .SWAP_CYC(60), .MENU_CYC(200), .FLASH_CYC(4)) fsm_monitor_inst (.*);
  fsm_operator fsm_operator_inst (.*);

  // Clock, 50 ns period
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Counts display flash toggles outside the idle display, whose point always flashes
  always @(posedge clk) begin
    if (disp.code != DC_IDLE && disp.lit !== lit_q) flips++;
    lit_q = disp.lit;
  end
  // Hang guard
  initial begin
    #(40000 * 50);
    n_fail++;
    wrap_up();
  end

  function automatic int unsigned life_step(input int unsigned l, input int unsigned n);
    return (l - 1 + n) % 24 + 1;
  endfunction : life_step
  function automatic int unsigned optime(input int unsigned h);
    return (h >= 20) ? (h & ~1) : h;
  endfunction : optime
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= d;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    chk(32'(bresp), 32'(RESP_OKAY));
    bready <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask : rdr
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rdr(a);
    chk(rd, e);
  endtask : rchk
  task automatic tick(input int unsigned n);
    repeat (n) begin
      half_month_tick <= 1'b1;
      @(posedge clk);
      half_month_tick <= 1'b0;
      @(posedge clk);
    end
  endtask : tick
  task automatic go(input int unsigned b, input fsm_code_t c);
    fsm_operator_inst.press(b, 4);
    chk(32'(disp.code), 32'(c));
  endtask : go
  task automatic enter(input int unsigned m);
    go(1, DC_QUERY);
    go(0, DC_WRITE);
    go(1, DC_ON);
    for (int i = 0; i < m; i++) go(0, wr_seq[i]);
  endtask : enter
  task automatic hold(input logic e);
    fork
      fsm_operator_inst.press(2, 70);
      begin
        repeat (50) @(posedge clk);
        chk(32'(lamp_test), 32'h1);
        chk(32'(sensor_isolate), 32'h0);
      end
    join
    chk(32'(sensor_isolate), 32'(e));
    chk(32'(lamp_test), 32'h0);
  endtask : hold
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up

  // Main sequence
  initial begin
    n_fail = 0;
    samples_checked = 0;
    flips = 0;
    rst = 1'b1;
    half_month_tick = 1'b0;
    today = {7'h10, 4'ha, 5'h1f};
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, araddr} = 16'h0;
    wdata = 32'h0;
    wstrb = 4'hf;
    void'($urandom(47));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    rchk(ADDR_CTRL, 32'h1);
    rchk(ADDR_LIFE, 32'h6);
    rchk(ADDR_STATUS, 32'h10000);
    rchk(ADDR_IRQ_MASK, 32'h0);
    rdr(8'h18);
    chk(32'(rs), 32'(RESP_SLVERR));
    life = 6;
    for (int i = 0; i < 12; i++) begin
      k = (i < 4) ? corner[i] : $urandom % 32;
      if (k >= 1 && k <= 24) life = k;
      wr(ADDR_LIFE, k);
      rchk(ADDR_LIFE, life);
    end
    $display("registers done");
    tick(25);
    rchk(ADDR_STATUS, 32'h10019);
    go(1, DC_QUERY);
    foreach (rd_seq[i]) begin
      go(1, rd_seq[i]);
      if (rd_seq[i] == DC_LIFE) chk(32'(disp.value), life);
      if (rd_seq[i] == DC_OPTIME) chk(32'(disp.value), optime(25));
    end
    $display("readout done");
    enter(4);
    go(0, DC_LIFE);
    go(1, DC_CHAN);
    go(1, DC_LIFE);
    chk(32'(disp.value), life);
    k = $urandom % 30 + 1;
    repeat (k) fsm_operator_inst.press(0, 4);
    life = life_step(life, k);
    chk(32'(disp.value), life);
    f0 = flips;
    fsm_operator_inst.press(1, 4);
    repeat (40) @(posedge clk);
    chk(flips - f0, 32'(ACK_TOGGLES));
    chk(32'(disp.code), 32'(DC_IDLE));
    rchk(ADDR_LIFE, life);
    rchk(ADDR_IRQ_STAT, 32'h4);
    wr(ADDR_IRQ_MASK, 32'h4);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h1);
    wr(ADDR_IRQ_MASK, 32'h0);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0);
    wr(ADDR_IRQ_MASK, 32'h4);
    wr(ADDR_IRQ_STAT, 32'h4);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0);
    rchk(ADDR_IRQ_STAT, 32'h0);
    $display("life edit done");
    enter(3);
    go(1, DC_CHAN);
    fsm_operator_inst.press(1, 4);
    repeat (40) @(posedge clk);
    rchk(ADDR_CTRL, 32'h0);
    hold(1'b0);
    wr(ADDR_CTRL, 32'h3);
    hold(1'b0);
    wr(ADDR_CTRL, 32'h1);
    hold(1'b1);
    chk(32'(fault_led), 32'h1);
    fsm_operator_inst.press(2, 4);
    chk(32'(sensor_isolate), 32'h0);
    $display("key hold done");
    tick(7);
    rchk(ADDR_STATUS, 32'h10007);
    enter(2);
    go(1, DC_CHAN);
    go(1, DC_SWAP);
    chk({29'h0, sensor_isolate, fault_out, fault_led}, 32'h7);
    rchk(ADDR_STATUS, 32'h10100);
    today <= {7'($urandom % 100), 4'($urandom % 12 + 1), 5'($urandom % 28 + 1)};
    fsm_operator_inst.press(2, 4);
    chk({29'h0, sensor_isolate, fault_out, fault_led}, 32'h0);
    chk(32'(disp.code), 32'(DC_IDLE));
    rchk(ADDR_LAST_DATE, {11'h0, today.day, 4'h0, today.month, 1'b0, today.year});
    $display("replacement done");
    go(1, DC_QUERY);
    repeat (220) @(posedge clk);
    chk(32'(disp.code), 32'(DC_IDLE));
    rdr(ADDR_IRQ_STAT);
    chk(32'(rd[IRQ_TMO]), 32'h1);
    $display("timeout done");
    wrap_up();
  end
endmodule : fsm_monitor_tb

bind fsm_monitor fsm_monitor_sva #(.LAMP_CYC(LAMP_CYC), .SWAP_CYC(SWAP_CYC), .MENU_CYC(MENU_CYC))
  fsm_monitor_sva_inst (.*);

//--- fsm_operator.sv
// Operator model: advance and confirm buttons and the reset key
module fsm_operator (
  // Clock
  input wire logic clk,
  // Pins, pulled high when released
  output logic btn_adv_n = 1'b1,
  output logic btn_cfm_n = 1'b1,
  output logic key_reset_n = 1'b1
);
  timeunit 1ns;
  timeprecision 1ns;
  // Press one control for n cycles, release and let the menu settle
  task automatic press(input int unsigned b, input int unsigned n);
    @(posedge clk);
    case (b)
      0: btn_adv_n <= 1'b0;
      1: btn_cfm_n <= 1'b0;
      default: key_reset_n <= 1'b0;
    endcase
    repeat (n) @(posedge clk);
    btn_adv_n <= 1'b1;
    btn_cfm_n <= 1'b1;
    key_reset_n <= 1'b1;
    repeat (5) @(posedge clk);
  endtask : press
endmodule : fsm_operator

//--- fsm_pkg.sv
// Shared constants, types and register map of the filter service monitor
package fsm_pkg;
  // Clock rate and documented times
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned LAMP_HOLD_S = 10;
  localparam int unsigned SWAP_HOLD_S = 15;
  localparam int unsigned MENU_TIMEOUT_S = 5;
  localparam int unsigned FLASH_HALF_MS = 250;
  localparam int unsigned LAMP_HOLD_CYC = LAMP_HOLD_S * CLK_HZ;
  localparam int unsigned SWAP_HOLD_CYC = SWAP_HOLD_S * CLK_HZ;
  localparam int unsigned MENU_TIMEOUT_CYC = MENU_TIMEOUT_S * CLK_HZ;
  localparam int unsigned FLASH_HALF_CYC = FLASH_HALF_MS * (CLK_HZ / 1000);
  // Counter widths
  localparam int HOLD_W = 29;
  localparam int TMO_W = 27;
  localparam int FLASH_W = 23;
  // Service life and elapsed time (elapsed in half months)
  localparam logic [4:0] LIFE_RST = 5'h06;
  localparam logic [4:0] LIFE_MIN = 5'h01;
  localparam logic [4:0] LIFE_MAX = 5'h18;
  localparam logic [5:0] ELAPSED_MAX = 6'h30;
  localparam logic [5:0] HALF_STEP_LIMIT = 6'h14;
  localparam logic [2:0] ACK_TOGGLES = 3'h6;
  localparam logic [7:0] CHAN_FIRST = 8'h01;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_LIFE = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
  localparam logic [7:0] ADDR_LAST_DATE = 8'h14;
  // Field positions and reset values
  localparam int CTRL_MON_BIT = 0;
  localparam int CTRL_KEYDIS_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h1;
  localparam int ST_SWAP_BIT = 8;
  localparam int ST_LAMP_BIT = 9;
  localparam int ST_MENU_LSB = 16;
  localparam int DATE_MONTH_LSB = 8;
  localparam int DATE_DAY_LSB = 16;
  localparam int IRQ_START = 0;
  localparam int IRQ_DONE = 1;
  localparam int IRQ_STORE = 2;
  localparam int IRQ_TMO = 3;
  localparam int IRQ_W = 4;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Menu states
  typedef enum logic [6:0] {
    S_IDLE = 7'h01, S_MODE = 7'h02, S_READ = 7'h04, S_ITEM = 7'h08,
    S_CHAN = 7'h10, S_EDIT = 7'h20, S_ACK = 7'h40
  } fsm_menu_t;
  // Items offered in write_config_mode
  typedef enum logic [1:0] {ITEM_ON, ITEM_LIFE, ITEM_SWAP, ITEM_OFF} fsm_item_t;
  // Items stepped through in query_view_mode
  typedef enum logic [2:0] {
    RD_CHAN, RD_MON, RD_LIFE, RD_REPL, RD_YEAR, RD_MONTH, RD_DAY, RD_OPTIME
  } fsm_rd_t;
  // Display symbols
  typedef enum logic [3:0] {
    DC_IDLE, DC_QUERY, DC_WRITE, DC_CHAN, DC_ON, DC_OFF, DC_LIFE, DC_REPL,
    DC_YEAR, DC_MONTH, DC_DAY, DC_OPTIME, DC_SWAP
  } fsm_code_t;
  typedef struct packed {
    logic [6:0] year;
    logic [3:0] month;
    logic [4:0] day;
  } fsm_date_t;
  typedef struct packed {
    fsm_code_t code;
    logic [7:0] value;
    logic lit;
  } fsm_disp_t;
endpackage : fsm_pkg

//--- fsm_sync.sv
// Two-flop synchroniser for an asynchronous operator pin
module fsm_sync #(
  parameter logic RST_VAL = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pin and synchronised level
  input wire logic d,
  output logic q
);
  logic meta_q;

  // Second flop is the only reader of the first
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : fsm_sync
